// ===== design/fan_cfg_map.vh
// Register offsets, field positions and reset values for the fan config and voltage block
`ifndef FAN_CFG_MAP_VH
`define FAN_CFG_MAP_VH
`define FAN_BEHAVIOUR_CONFIG_IDX 8'h10
`define OVERRIDE_HYST_CONFIG_IDX 8'h11
`define VOLTAGE_2V5_IDX 8'h20
`define CORE_VOLTAGE_IDX 8'h21
`define SUPPLY_VOLTAGE_IDX 8'h22
`define VOLTAGE_5V_IDX 8'h23
`define VOLTAGE_12V_IDX 8'h24
`define EXT_RES_1_IDX 8'h76
`define EXT_RES_2_IDX 8'h77
`define LOCK_CTRL_IDX 8'h40
`define MONITOR_STATUS_IDX 8'h41
`define CONFIG_RESET 8'h00
`define READING_RESET 8'h00
`define BIT_REMOTE_A 0
`define BIT_ONCHIP 1
`define BIT_REMOTE_B 2
`define BIT_OVR_MANUAL 3
`define BIT_FOLLOWER 4
`define BIT_LEADER 5
`define BIT_UNDERVOLT 6
`define BIT_EXTRA 7
`define BIT_HYST_DIS 0
`define BIT_LOCK 1
`define SPINUP_TIME_US 2
`define CLK_MHZ 50
`define SPINUP_CYCLES (`SPINUP_TIME_US * `CLK_MHZ)
`endif

// ===== design/reading_freeze.v
// One voltage reading holder with freeze on extended-register read
`timescale 1ns/1ps
`include "fan_cfg_map.vh"
module reading_freeze (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Conversion side
    input wire [9:0] sample_i,
    input wire sample_valid_i,
    // Freeze control
    input wire freeze_set_i,
    input wire msb_read_i,
    input wire ext_read_i,
    // Held value
    output reg [9:0] value_o,
    output reg frozen_o
);
    reg msb_pend_reg;
    reg ext_pend_reg;
    wire msb_pend_next;
    wire ext_pend_next;
    assign msb_pend_next = freeze_set_i | (msb_pend_reg & ~msb_read_i);
    assign ext_pend_next = (ext_pend_reg & ~ext_read_i) | (freeze_set_i & ~ext_read_i);

    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            value_o <= {2'h0, `READING_RESET};
            msb_pend_reg <= 1'b0;
            ext_pend_reg <= 1'b0;
            frozen_o <= 1'b0;
        end
        else
        begin
            // Freeze from the extended read until the MSB register is read
            msb_pend_reg <= msb_pend_next;
            ext_pend_reg <= ext_pend_next;
            frozen_o <= msb_pend_next | ext_pend_next;
            if (sample_valid_i && !frozen_o && !freeze_set_i)
                value_o <= sample_i;
        end
    end
endmodule // reading_freeze

// ===== design/fan_config_voltage_readout.v
// Fan configuration registers and voltage reading registers on APB
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "fan_cfg_map.vh"
module fan_config_voltage_readout (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Conversion results, 10 bits per channel, same clock
    input wire [49:0] conv_data_i,
    input wire [4:0] conv_valid_i,
    input wire [7:0] core_low_limit_i,
    // Pins from outside
    input wire thermal_override_i,
    input wire manual_mode_i,
    input wire alert_enable_i,
    // Fan control outputs
    output reg smoothing_x4_remote_a_o,
    output reg smoothing_x4_onchip_o,
    output reg smoothing_x4_remote_b_o,
    output reg smoothing_extra_stretch_o,
    output reg override_active_o,
    output reg override_hysteresis_disable_o,
    output reg sync_follower_enable_o,
    output reg sync_leader_enable_o,
    output reg processor_hot_monitor_en_o,
    output reg undervolt_status_o,
    output reg alert_o,
    output reg sleep_o,
    output reg fan_spinup_o,
    output reg fans_force_full_o
);
    function sel_idx;
        input [11:0] addr;
        input [7:0] idx;
        begin
            sel_idx = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
        end
    endfunction

    localparam [31:0] SPINUP_TOTAL = `SPINUP_CYCLES;
    localparam [15:0] SPINUP_COUNT = SPINUP_TOTAL[15:0];
    localparam ST_NORMAL = 2'h0;
    localparam ST_UNDER = 2'h1;
    localparam ST_SPIN = 2'h2;

    reg [7:0] fan_behaviour_config_reg;
    reg [7:0] override_hysteresis_config_reg;
    reg lock_reg;
    reg status_bit_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] spin_cnt_reg;
    reg [1:0] thermal_override_sync_reg;
    reg [1:0] manual_sync_reg;
    reg [1:0] alert_en_sync_reg;
    wire [49:0] held_value;
    wire [4:0] held_frozen;
    wire access;
    wire wr_en;
    wire rd_en;
    wire ext1_rd;
    wire ext2_rd;
    wire [4:0] msb_rd;
    wire [4:0] ext_rd;
    wire [4:0] freeze_set;
    wire core_low;
    wire mapped;
    reg [7:0] rd_byte;

    assign access = psel & penable & ~pready;
    assign wr_en = access & pwrite;
    assign rd_en = access & ~pwrite;
    assign ext1_rd = rd_en & sel_idx(paddr, `EXT_RES_1_IDX);
    assign ext2_rd = rd_en & sel_idx(paddr, `EXT_RES_2_IDX);
    // Channel 0..3 live in ext 1, channel 4 in ext 2
    assign freeze_set = {ext2_rd, {4{ext1_rd}}};
    assign ext_rd = freeze_set;
    // Core channel MSBs against the low limit
    assign core_low = held_value[19:12] < core_low_limit_i;
    assign mapped = sel_idx(paddr, `FAN_BEHAVIOUR_CONFIG_IDX)
        | sel_idx(paddr, `OVERRIDE_HYST_CONFIG_IDX)
        | sel_idx(paddr, `VOLTAGE_2V5_IDX) | sel_idx(paddr, `CORE_VOLTAGE_IDX)
        | sel_idx(paddr, `SUPPLY_VOLTAGE_IDX) | sel_idx(paddr, `VOLTAGE_5V_IDX)
        | sel_idx(paddr, `VOLTAGE_12V_IDX) | sel_idx(paddr, `EXT_RES_1_IDX)
        | sel_idx(paddr, `EXT_RES_2_IDX) | sel_idx(paddr, `LOCK_CTRL_IDX)
        | sel_idx(paddr, `MONITOR_STATUS_IDX);

    // Per channel reading holders
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : gen_chan
            localparam [31:0] CH_IDX = `VOLTAGE_2V5_IDX + g;
            assign msb_rd[g] = rd_en & sel_idx(paddr, CH_IDX[7:0]);
            reading_freeze u_hold (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .sample_i(conv_data_i[g*10 +: 10]),
                .sample_valid_i(conv_valid_i[g]),
                .freeze_set_i(freeze_set[g]),
                .msb_read_i(msb_rd[g]),
                .ext_read_i(ext_rd[g]),
                .value_o(held_value[g*10 +: 10]),
                .frozen_o(held_frozen[g])
            );
        end
    endgenerate

    // Read mux
    always @*
    begin
        rd_byte = 8'h00;
        if (sel_idx(paddr, `FAN_BEHAVIOUR_CONFIG_IDX))
            rd_byte = fan_behaviour_config_reg;
        else if (sel_idx(paddr, `OVERRIDE_HYST_CONFIG_IDX))
            rd_byte = override_hysteresis_config_reg;
        else if (sel_idx(paddr, `VOLTAGE_2V5_IDX))
            rd_byte = held_value[9:2];
        else if (sel_idx(paddr, `CORE_VOLTAGE_IDX))
            rd_byte = held_value[19:12];
        else if (sel_idx(paddr, `SUPPLY_VOLTAGE_IDX))
            rd_byte = held_value[29:22];
        else if (sel_idx(paddr, `VOLTAGE_5V_IDX))
            rd_byte = held_value[39:32];
        else if (sel_idx(paddr, `VOLTAGE_12V_IDX))
            rd_byte = held_value[49:42];
        else if (sel_idx(paddr, `EXT_RES_1_IDX))
            rd_byte = {held_value[31:30], held_value[21:20], held_value[11:10], held_value[1:0]};
        else if (sel_idx(paddr, `EXT_RES_2_IDX))
            rd_byte = {6'h00, held_value[41:40]};
        else if (sel_idx(paddr, `LOCK_CTRL_IDX))
            rd_byte = {6'h00, lock_reg, 1'b0};
        else if (sel_idx(paddr, `MONITOR_STATUS_IDX))
            rd_byte = {5'h00, ~processor_hot_monitor_en_o, fan_spinup_o, status_bit_reg};
    end

    // APB answer, one wait state
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access;
            pslverr <= access & ~mapped;
            if (rd_en)
                prdata <= {24'h000000, rd_byte};
        end
    end

    // Configuration registers and lock
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fan_behaviour_config_reg <= `CONFIG_RESET;
            override_hysteresis_config_reg <= `CONFIG_RESET;
            lock_reg <= 1'b0;
        end
        else if (wr_en)
        begin
            if (sel_idx(paddr, `LOCK_CTRL_IDX) && pwdata[`BIT_LOCK])
                lock_reg <= 1'b1;
            if (!lock_reg && sel_idx(paddr, `FAN_BEHAVIOUR_CONFIG_IDX))
                fan_behaviour_config_reg <= pwdata[7:0];
            if (!lock_reg && sel_idx(paddr, `OVERRIDE_HYST_CONFIG_IDX))
                override_hysteresis_config_reg <= {7'h00, pwdata[`BIT_HYST_DIS]};
        end
    end

    // Pin synchronisers
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            thermal_override_sync_reg <= 2'h0;
            manual_sync_reg <= 2'h0;
            alert_en_sync_reg <= 2'h0;
        end
        else
        begin
            thermal_override_sync_reg <= {thermal_override_sync_reg[0], thermal_override_i};
            manual_sync_reg <= {manual_sync_reg[0], manual_mode_i};
            alert_en_sync_reg <= {alert_en_sync_reg[0], alert_enable_i};
        end
    end

    // Undervolt state machine
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL:
                if (fan_behaviour_config_reg[`BIT_UNDERVOLT] && core_low)
                    state_next = ST_UNDER;
            ST_UNDER:
                if (!core_low)
                    state_next = ST_SPIN;
            ST_SPIN:
                if (spin_cnt_reg == 16'h0001)
                    state_next = ST_NORMAL;
            default:
                state_next = ST_NORMAL;
        endcase
    end

    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_NORMAL;
            spin_cnt_reg <= 16'h0000;
            status_bit_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_UNDER && state_next == ST_SPIN)
                spin_cnt_reg <= SPINUP_COUNT;
            else if (spin_cnt_reg != 16'h0000)
                spin_cnt_reg <= spin_cnt_reg - 16'h0001;
            // Set wins over read-clear
            if (state_reg == ST_NORMAL && state_next == ST_UNDER)
                status_bit_reg <= 1'b1;
            else if (rd_en && sel_idx(paddr, `MONITOR_STATUS_IDX))
                status_bit_reg <= 1'b0;
        end
    end

    // Registered control outputs
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            smoothing_x4_remote_a_o <= 1'b0;
            smoothing_x4_onchip_o <= 1'b0;
            smoothing_x4_remote_b_o <= 1'b0;
            smoothing_extra_stretch_o <= 1'b0;
            override_active_o <= 1'b0;
            override_hysteresis_disable_o <= 1'b0;
            sync_follower_enable_o <= 1'b0;
            sync_leader_enable_o <= 1'b0;
            processor_hot_monitor_en_o <= 1'b1;
            undervolt_status_o <= 1'b0;
            alert_o <= 1'b0;
            sleep_o <= 1'b0;
            fan_spinup_o <= 1'b0;
            fans_force_full_o <= 1'b0;
        end
        else
        begin
            smoothing_x4_remote_a_o <= fan_behaviour_config_reg[`BIT_REMOTE_A];
            smoothing_x4_onchip_o <= fan_behaviour_config_reg[`BIT_ONCHIP];
            smoothing_x4_remote_b_o <= fan_behaviour_config_reg[`BIT_REMOTE_B];
            smoothing_extra_stretch_o <= fan_behaviour_config_reg[`BIT_EXTRA];
            override_active_o <= thermal_override_sync_reg[1]
                & (~manual_sync_reg[1] | fan_behaviour_config_reg[`BIT_OVR_MANUAL]);
            override_hysteresis_disable_o <= override_hysteresis_config_reg[`BIT_HYST_DIS];
            sync_follower_enable_o <= fan_behaviour_config_reg[`BIT_FOLLOWER];
            sync_leader_enable_o <= fan_behaviour_config_reg[`BIT_LEADER];
            processor_hot_monitor_en_o <= (state_next != ST_UNDER);
            undervolt_status_o <= status_bit_reg;
            alert_o <= status_bit_reg & alert_en_sync_reg[1];
            sleep_o <= (state_next == ST_UNDER);
            fan_spinup_o <= (state_next == ST_SPIN);
            // Override forces fans full, but in manual mode only when BIT_OVR_MANUAL is set
            fans_force_full_o <= thermal_override_sync_reg[1]
                & (~manual_sync_reg[1] | fan_behaviour_config_reg[`BIT_OVR_MANUAL]);
        end
    end
endmodule // fan_config_voltage_readout

// ===== verif/fan_cfg_monitor.sv
// Assertion checker for the fan config and voltage block
`timescale 1ns/1ps
module fan_cfg_monitor (
    // Clock, reset and bus
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and fan outputs
    input wire logic thermal_override_i,
    input wire logic manual_mode_i,
    input wire logic smoothing_x4_remote_a_o,
    input wire logic smoothing_x4_onchip_o,
    input wire logic smoothing_x4_remote_b_o,
    input wire logic smoothing_extra_stretch_o,
    input wire logic override_active_o,
    input wire logic fans_force_full_o,
    input wire logic override_hysteresis_disable_o,
    input wire logic sync_follower_enable_o,
    input wire logic sync_leader_enable_o,
    input wire logic processor_hot_monitor_en_o,
    input wire logic sleep_o,
    input wire logic fan_spinup_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic lock_reg;
    logic [7:0] wd_reg;
    wire done = psel && penable && pready && pwrite;
    // Lock seen on the bus, last write byte
    always @(posedge ref_clk_i or posedge rst_i)
        if (rst_i)
            lock_reg <= 1'h0;
        else if (done && paddr == 12'h100 && pwdata[1])
            lock_reg <= 1'h1;
    always @(posedge ref_clk_i)
        if (done)
            wd_reg <= pwdata[7:0];
    sequence cfg_wr;
        done && paddr == 12'h040;
    endsequence
    sequence wake_edge;
        sleep_o ##1 !sleep_o;
    endsequence
    a_smooth_bits: assert property (cfg_wr ##0 !lock_reg |-> ##2
        {smoothing_extra_stretch_o, smoothing_x4_remote_b_o, smoothing_x4_onchip_o,
        smoothing_x4_remote_a_o} == {wd_reg[7], wd_reg[2:0]}) else $error("smoothing flags");
    a_sync_roles: assert property (cfg_wr ##0 !lock_reg |-> ##2
        {sync_leader_enable_o, sync_follower_enable_o} == wd_reg[5:4]) else $error("sync roles");
    a_hyst_bit: assert property (done && paddr == 12'h044 && !lock_reg |-> ##2
        override_hysteresis_disable_o == wd_reg[0]) else $error("hysteresis flag");
    a_lock_holds: assert property (cfg_wr ##0 lock_reg |=>
        $stable({sync_leader_enable_o, sync_follower_enable_o, smoothing_x4_remote_a_o}) [*3])
        else $error("locked write changed outputs");
    a_override_on: assert property ((thermal_override_i && !manual_mode_i) [*5] |->
        override_active_o && fans_force_full_o) else $error("override not active");
    a_override_off: assert property (!thermal_override_i [*5] |-> !override_active_o)
        else $error("override without cause");
    a_sleep_hot: assert property (sleep_o |-> !processor_hot_monitor_en_o)
        else $error("hot monitor on in undervolt");
    a_wake_spinup: assert property (wake_edge |-> ##[0:3] fan_spinup_o &&
        processor_hot_monitor_en_o) else $error("no spin-up on recovery");
    a_spinup_len: assert property ($rose(fan_spinup_o) |-> fan_spinup_o [*8])
        else $error("spin-up too short");
    a_ready_pulse: assert property (pready |=> !pready && !pslverr) else $error("ready not a pulse");
endmodule // fan_cfg_monitor
bind fan_config_voltage_readout fan_cfg_monitor u_mon (.*);

// ===== verif/host_apb_model.sv
// Host controller model driving the APB register bus
`timescale 1ns/1ps
module host_apb_model (
    // Clock
    input wire logic ref_clk_i,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    integer hangs;
    integer gap;
    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        hangs = 0;
        gap = 0;
    end
    // One transfer, gap adds idle cycles for a slow host
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        integer n;
        begin
            psel <= 1'h1;
            paddr <= a;
            pwrite <= w;
            pwdata <= (a == 12'h044) ? (d & 32'h00000001) : d;
            @(posedge ref_clk_i);
            penable <= 1'h1;
            n = 0;
            @(posedge ref_clk_i);
            while (!pready && n < 40)
            begin
                @(posedge ref_clk_i);
                n++;
            end
            if (!pready)
                hangs++;
            q = prdata;
            e = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            repeat (1 + gap) @(posedge ref_clk_i);
        end
    endtask
endmodule // host_apb_model

// ===== verif/tb_top.sv
// Self-checking bench for the fan config and voltage block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    logic ref_clk_i;
    logic rst_i;
    logic [49:0] conv_data_i;
    logic [4:0] conv_valid_i;
    logic [7:0] core_low_limit_i;
    logic thermal_override_i, manual_mode_i, alert_enable_i;
    wire psel, penable, pwrite, pready, pslverr;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire smoothing_x4_remote_a_o, smoothing_x4_onchip_o, smoothing_x4_remote_b_o;
    wire smoothing_extra_stretch_o, override_active_o, override_hysteresis_disable_o;
    wire sync_follower_enable_o, sync_leader_enable_o, processor_hot_monitor_en_o;
    wire undervolt_status_o, alert_o, sleep_o, fan_spinup_o, fans_force_full_o;
    integer errors, checks, seed, i;
    logic [31:0] q, cw;
    logic e;
    logic [11:0] a;
    logic [49:0] c;
    host_apb_model u_host (.*);
    fan_config_voltage_readout dut_u (.*);
    function logic [7:0] msb(input logic [49:0] v, input integer k);
        msb = v[k * 10 + 2 +: 8];
    endfunction
    function logic [7:0] ext1(input logic [49:0] v);
        ext1 = {v[31:30], v[21:20], v[11:10], v[1:0]};
    endfunction
    function logic pick(input integer s);
        pick = s ? fan_spinup_o : sleep_o;
    endfunction
    task rd(input logic [11:0] ad);
        u_host.xfer(ad, 1'h0, 32'h00000000, q, e);
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] v);
        u_host.xfer(ad, 1'h1, v, q, e);
    endtask
    task load(input logic [49:0] v);
        conv_data_i <= v;
        conv_valid_i <= 5'h1F;
        @(posedge ref_clk_i);
        conv_valid_i <= 5'h00;
        @(posedge ref_clk_i);
    endtask
    task wait_on(input integer s, input logic v);
        integer n;
        begin
            n = 0;
            while (pick(s) !== v && n < 300)
            begin
                @(posedge ref_clk_i);
                n++;
            end
            `CHK("wait", v, pick(s))
        end
    endtask
    task close_out;
        errors = errors + u_host.hangs;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        ref_clk_i = 1'h0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        close_out;
    end
    initial
    begin
        {errors, checks, seed} = {32'h0, 32'h0, 32'h2673};
        {rst_i, conv_data_i, conv_valid_i, core_low_limit_i} = {1'h1, 50'h0, 5'h00, 8'h00};
        {thermal_override_i, manual_mode_i, alert_enable_i} = 3'h1;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        @(posedge ref_clk_i);
        for (i = 0; i < 7; i++)
        begin
            a = (i < 2) ? 12'h040 + 12'(i * 4) : 12'h078 + 12'(i * 4);
            rd(a);
            `CHK("reset value", 32'h00000000, q)
        end
        rd(12'h300);
        `CHK("unmapped", 1'h1, e)
        for (i = 0; i < 8; i++)
        begin
            cw = $random(seed) & 32'h000000BF;
            u_host.gap = i % 3;
            wr(12'h040, cw);
            rd(12'h040);
            `CHK("config one", cw, q)
            cw = $random(seed);
            wr(12'h044, cw);
            rd(12'h044);
            `CHK("config two", {31'h0, cw[0]}, q)
        end
        thermal_override_i <= 1'h1;
        for (i = 0; i < 3; i++)
        begin
            manual_mode_i <= (i < 2);
            wr(12'h040, 32'(i * 8));
            repeat (5) @(posedge ref_clk_i);
            `CHK("override", i > 0, override_active_o)
        end
        thermal_override_i <= 1'h0;
        c = {$random(seed), $random(seed)};
        load(c);
        for (i = 0; i < 5; i++)
        begin
            rd(12'h080 + 12'(i * 4));
            `CHK("reading", {24'h0, msb(c, i)}, q)
        end
        rd(12'h1D8);
        `CHK("ext one", {24'h0, ext1(c)}, q)
        load(~c);
        for (i = 0; i < 5; i++)
        begin
            rd(12'h080 + 12'(i * 4));
            `CHK("frozen", {24'h0, msb(i < 4 ? c : ~c, i)}, q)
        end
        load(50'h0);
        rd(12'h080);
        `CHK("released", 32'h00000000, q)
        core_low_limit_i <= 8'hFF;
        wr(12'h040, 32'h00000040);
        wait_on(0, 1'h1);
        @(posedge ref_clk_i);
        `CHK("alert", 1'h1, alert_o)
        `CHK("undervolt status", 1'h1, undervolt_status_o)
        rd(12'h104);
        `CHK("status", 1'h1, q[0])
        core_low_limit_i <= 8'h00;
        wait_on(1, 1'h1);
        `CHK("hot monitor", 1'h1, processor_hot_monitor_en_o)
        wait_on(1, 1'h0);
        wr(12'h100, 32'h00000002);
        wr(12'h040, 32'h0000003F);
        rd(12'h040);
        `CHK("locked", 32'h00000040, q)
        close_out;
    end
endmodule // tb_top
